// File: hdl/srsq_params.svh
// constants of the serial register access sequencer
`ifndef SRSQ_PARAMS_SVH
`define SRSQ_PARAMS_SVH

`define SRSQ_DEV_ADDR_RST     2'h1
`define SRSQ_RD_LOOP_RST      2'h2
`define SRSQ_WR_LOOP_RST      1'h1
`define SRSQ_WIDTH_RST        2'h1
`define SRSQ_WIDTH_24         2'h1
`define SRSQ_WIDTH_16         2'h0
`define SRSQ_WIDTH_32A        2'h2
`define SRSQ_WIDTH_32B        2'h3
`define SRSQ_BITS_16          6'h10
`define SRSQ_BITS_24          6'h18
`define SRSQ_BITS_32          6'h20
`define SRSQ_CTRL_BITS        6'h08
`define SRSQ_LOCK_KEY         8'hA5
`define SRSQ_LOCK_REG         5'h1F
`define SRSQ_RO_LAST          5'h07
`define SRSQ_ADC_LAST         5'h05
`define SRSQ_FIFO_WIDTH       32
`define SRSQ_FIFO_DEPTH       4

`endif

// File: hdl/srsq_pkg.sv
// types of the serial register access sequencer
package srsq_pkg;
  typedef enum logic [1:0] {
    SRSQ_LOOP_STATIC,
    SRSQ_LOOP_GROUP,
    SRSQ_LOOP_TYPE,
    SRSQ_LOOP_FULL
  } srsq_loop_e;

  typedef enum logic [1:0] {
    SRSQ_ST_IDLE,
    SRSQ_ST_CTRL,
    SRSQ_ST_READ,
    SRSQ_ST_WRITE
  } srsq_state_e;
endpackage : srsq_pkg

// File: hdl/srsq_sync.sv
// two flip-flop level synchroniser with configurable reset level
`timescale 1ns/1ps
module srsq_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : srsq_sync

// File: hdl/srsq_fifo.sv
// small valid/ready FIFO holding written register words
`timescale 1ns/1ps
module srsq_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end
endmodule : srsq_fifo

// File: hdl/srsq_seq.sv
// spi slave command sequencer: control byte, looping reads and writes
`include "srsq_params.svh"
`timescale 1ns/1ps
module srsq_seq #(
  // bit i set: index i opens a new group / type set (arbitrary boundaries)
  parameter logic [31:0] GROUP_START = 32'h5555_0155,
  parameter logic [31:0] TYPE_START  = 32'h0001_0101,
  // bit i set: index i exists in the map
  parameter logic [31:0] DEFINED     = 32'hFFFF_FFFF
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // spi pins
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        sdi,
  output logic             sdo_o,
  output logic             sdo_oe,
  // configuration from the comm_status_config_register
  input  wire logic [1:0]  dev_addr,
  input  wire logic [1:0]  rd_loop,
  input  wire logic        wr_loop,
  input  wire logic [1:0]  data_width,
  input  wire logic [7:0]  lock_code,
  input  wire logic        conversion_ready_pulse,
  // register file side
  output logic [4:0]       rd_index,
  input  wire logic [31:0] rd_word,
  output logic             wr_valid,
  output logic [4:0]       wr_index,
  output logic [31:0]      wr_data,
  input  wire logic        wr_ready,
  output logic             busy,
  output logic [4:0]       ptr
);
  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic cs_s;
  logic sck_s;
  logic sdi_s;
  logic rdy_s;

  srsq_sync #(.RST_VAL(1'b1)) u_cs (.ref_clk(ref_clk), .arst_n(arst_n),
    .async_in(cs_n), .sync_out(cs_s));
  srsq_sync #(.RST_VAL(1'b0)) u_sck (.ref_clk(ref_clk), .arst_n(arst_n),
    .async_in(sck), .sync_out(sck_s));
  srsq_sync #(.RST_VAL(1'b0)) u_sdi (.ref_clk(ref_clk), .arst_n(arst_n),
    .async_in(sdi), .sync_out(sdi_s));
  srsq_sync #(.RST_VAL(1'b1)) u_rdy (.ref_clk(ref_clk), .arst_n(arst_n),
    .async_in(conversion_ready_pulse), .sync_out(rdy_s));

  logic cs_d1_q;
  logic sck_d1_q;
  logic rdy_d1_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_d1_q  <= 1'b1;
      sck_d1_q <= 1'b0;
      rdy_d1_q <= 1'b1;
    end else begin
      cs_d1_q  <= cs_s;
      sck_d1_q <= sck_s;
      rdy_d1_q <= rdy_s;
    end
  end

  wire cs_rise  = cs_s && !cs_d1_q;
  wire sck_rise = !cs_s && sck_s && !sck_d1_q;
  wire sck_fall = !cs_s && !sck_s && sck_d1_q;
  wire rdy_fall = !rdy_s && rdy_d1_q;

  // ------------------------------------------------------------------
  // state and counters
  // ------------------------------------------------------------------
  srsq_pkg::srsq_state_e st_q;
  srsq_pkg::srsq_state_e st_d;
  logic [5:0]  bit_q;
  logic [31:0] shin_q;
  logic [31:0] shout_q;
  logic [4:0]  ptr_q;
  logic        sdo_q;
  logic        oe_q;
  logic        word_done_q;   // a word of an ADC index was just loaded, cleared on the next sck fall

  wire [5:0] word_bits =
    (data_width == `SRSQ_WIDTH_16) ? `SRSQ_BITS_16 :
    (data_width == `SRSQ_WIDTH_24) ? `SRSQ_BITS_24 : `SRSQ_BITS_32;

  // left-align the word so the msb leaves first
  wire [31:0] load_word =
    (word_bits == `SRSQ_BITS_16) ? {rd_word[15:0], 16'h0000} :
    (word_bits == `SRSQ_BITS_24) ? {rd_word[23:0], 8'h00} : rd_word;

  wire [7:0] ctrl_byte = {shin_q[6:0], sdi_s};
  wire       ctrl_done = (st_q == srsq_pkg::SRSQ_ST_CTRL) && sck_rise &&
                         (bit_q == `SRSQ_CTRL_BITS - 6'h01);
  wire       ctrl_hit  = (ctrl_byte[7:6] == dev_addr);
  wire       ctrl_rd   = ctrl_byte[0];
  wire [4:0] ctrl_idx  = ctrl_byte[5:1];

  wire       last_bit  = sck_rise && (bit_q == word_bits - 6'h01);
  wire       rd_last   = (st_q == srsq_pkg::SRSQ_ST_READ) && last_bit;
  wire       wr_last   = (st_q == srsq_pkg::SRSQ_ST_WRITE) && last_bit;

  // ------------------------------------------------------------------
  // pointer advance within the active set
  // ------------------------------------------------------------------
  function automatic logic [4:0] srsq_next(input logic [4:0] cur,
                                           input logic [31:0] starts,
                                           input logic full);
    logic [4:0] nxt;
    logic [4:0] first;
    nxt   = 5'(cur + 5'h01);
    first = cur;
    for (int i = 0; i < 32; i++) begin
      if (i[4:0] <= cur && (starts[i] || i == 0)) begin
        first = i[4:0];
      end
    end
    if (full) begin
      srsq_next = nxt;
    end else if (cur == 5'h1F || starts[nxt]) begin
      srsq_next = first;
    end else begin
      srsq_next = nxt;
    end
  endfunction : srsq_next

  wire [4:0] rd_next =
    (rd_loop == srsq_pkg::SRSQ_LOOP_STATIC) ? ptr_q :
    (rd_loop == srsq_pkg::SRSQ_LOOP_GROUP)  ?
      srsq_next(ptr_q, GROUP_START, 1'b0) :
    (rd_loop == srsq_pkg::SRSQ_LOOP_TYPE)   ?
      srsq_next(ptr_q, TYPE_START, 1'b0) :
      srsq_next(ptr_q, 32'h0, 1'b1);

  wire [4:0] wr_next = wr_loop ? srsq_next(ptr_q, TYPE_START, 1'b0)
                               : ptr_q;

  wire unlocked  = (lock_code == `SRSQ_LOCK_KEY);
  wire writable  = DEFINED[ptr_q] && (ptr_q > `SRSQ_RO_LAST) &&
                   (unlocked || ptr_q == `SRSQ_LOCK_REG);
  wire [31:0] wr_word = {shin_q[30:0], sdi_s};
  wire [31:0] wr_aligned =
    (word_bits == `SRSQ_BITS_16) ? {16'h0000, wr_word[15:0]} :
    (word_bits == `SRSQ_BITS_24) ? {8'h00, wr_word[23:0]} : wr_word;

  // ------------------------------------------------------------------
  // write buffer
  // ------------------------------------------------------------------
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [36:0] fifo_out_data;
  wire         fifo_push = wr_last && writable;

  srsq_fifo #(.WIDTH(`SRSQ_FIFO_WIDTH + 5), .DEPTH(`SRSQ_FIFO_DEPTH))
    u_fifo (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .flush    (1'b0),
      .in_valid (fifo_push),
      .in_ready (fifo_in_ready),
      .in_data  ({ptr_q, wr_aligned}),
      .out_valid(fifo_out_valid),
      .out_ready(wr_ready && !wr_valid),
      .out_data (fifo_out_data)
    );

  // ------------------------------------------------------------------
  // foreign chip id: stay deaf until chip select rises
  // ------------------------------------------------------------------
  // without this the idle state would reopen the control phase and
  // could take a data word addressed to another chip as a command
  logic skip_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      skip_q <= 1'b0;
    end else if (cs_s) begin
      skip_q <= 1'b0;
    end else if (ctrl_done && !ctrl_hit) begin
      skip_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // main state machine
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      srsq_pkg::SRSQ_ST_IDLE: begin
        if (!cs_s && !skip_q) begin
          st_d = srsq_pkg::SRSQ_ST_CTRL;
        end
      end
      srsq_pkg::SRSQ_ST_CTRL: begin
        if (ctrl_done) begin
          if (!ctrl_hit) begin
            st_d = srsq_pkg::SRSQ_ST_IDLE;
          end else if (ctrl_rd) begin
            st_d = srsq_pkg::SRSQ_ST_READ;
          end else begin
            st_d = srsq_pkg::SRSQ_ST_WRITE;
          end
        end
      end
      srsq_pkg::SRSQ_ST_READ: st_d = st_q;
      srsq_pkg::SRSQ_ST_WRITE: st_d = st_q;
      default: st_d = srsq_pkg::SRSQ_ST_IDLE;
    endcase
    if (cs_s) begin
      st_d = srsq_pkg::SRSQ_ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= srsq_pkg::SRSQ_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // bit counter and input shifter; reads ignore sdi after the control byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_q  <= '0;
      shin_q <= '0;
    end else if (cs_s || cs_rise) begin
      bit_q  <= '0;
    end else if (sck_rise) begin
      if (ctrl_done || last_bit) begin
        bit_q <= '0;
      end else begin
        bit_q <= 6'(bit_q + 6'h01);
      end
      if (st_q != srsq_pkg::SRSQ_ST_READ) begin
        shin_q <= {shin_q[30:0], sdi_s};
      end
    end
  end

  // address pointer; an unwritable target stalls it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= '0;
    end else if (ctrl_done) begin
      ptr_q <= ctrl_idx;
    end else if (rd_last) begin
      ptr_q <= rd_next;
    end else if (wr_last && writable) begin
      ptr_q <= wr_next;
    end
  end

  // output shifter, updated on sck falling edges and on a ready fall after an ADC word
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shout_q     <= '0;
      sdo_q       <= 1'b0;
      oe_q        <= 1'b0;
      word_done_q <= 1'b0;
    end else if (cs_s) begin
      oe_q        <= 1'b0;
      word_done_q <= 1'b0;
    end else if (st_q == srsq_pkg::SRSQ_ST_READ) begin
      oe_q <= 1'b1;
      if (sck_fall) begin
        if (bit_q == 6'h00) begin
          // word start: fresh word; after a full word in mode 0 this
          // already shows the next msb on the last falling edge
          sdo_q       <= load_word[31];
          shout_q     <= {load_word[30:0], 1'b0};
          word_done_q <= (ptr_q <= `SRSQ_ADC_LAST);
        end else begin
          sdo_q       <= shout_q[31];
          shout_q     <= {shout_q[30:0], 1'b0};
          word_done_q <= 1'b0;
        end
      end else if (rdy_fall && word_done_q && !sck_s) begin
        sdo_q <= load_word[31];
        // reload the rest too, so the next bits match the fresh msb
        shout_q <= {load_word[30:0], 1'b0};
      end
      // with sck idle high nothing moves: the lsb stays on the pin
    end else begin
      oe_q <= 1'b0;
    end
  end

  // write handoff register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_valid <= 1'b0;
      wr_index <= '0;
      wr_data  <= '0;
    end else if (wr_valid) begin
      wr_valid <= 1'b0;
    end else if (fifo_out_valid && wr_ready) begin
      wr_valid <= 1'b1;
      wr_index <= fifo_out_data[36:32];
      wr_data  <= fifo_out_data[31:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_index <= '0;
      busy     <= 1'b0;
      ptr      <= '0;
    end else begin
      rd_index <= (ctrl_done) ? ctrl_idx : (rd_last ? rd_next : ptr_q);
      busy     <= (st_q != srsq_pkg::SRSQ_ST_IDLE) || fifo_out_valid
                  || !fifo_in_ready;
      ptr      <= ptr_q;
    end
  end

  assign sdo_o  = sdo_q;
  assign sdo_oe = oe_q;
endmodule : srsq_seq

// File: test/srsq_seq_properties.sv
// port assertions for the serial register access sequencer
`include "srsq_params.svh"
`timescale 1ns/1ps
module srsq_seq_properties (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       sdo_o,
  input wire logic       sdo_oe,
  input wire logic [7:0] lock_code,
  input wire logic       wr_valid,
  input wire logic [4:0] wr_index,
  input wire logic       wr_ready,
  input wire logic [4:0] ptr
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  idle_oe_a: assert property (cs_n [*8] |-> !sdo_oe)
    else $error("serial output driven while deselected");
  ctrl_quiet_a: assert property ($fell(cs_n) |-> !sdo_oe [*8])
    else $error("serial output driven during control byte");
  write_quiet_a: assert property (wr_valid |-> !sdo_oe)
    else $error("serial output driven during a write");
  ro_write_a: assert property (wr_valid |-> wr_index > `SRSQ_RO_LAST)
    else $error("write issued to a read-only index");
  lock_write_a: assert property (
    wr_valid && lock_code != `SRSQ_LOCK_KEY |-> wr_index == `SRSQ_LOCK_REG)
    else $error("write passed while locked");
  wr_pulse_a: assert property (
    wr_valid |-> $past(wr_ready) ##1 !wr_valid)
    else $error("write strobe longer than one cycle or unaccepted");
  sdo_fall_a: assert property (
    $changed(sdo_o) && sdo_oe && $past(sdo_oe) |-> !$past(sck, 2))
    else $error("serial output moved away from a falling sck");
  ptr_idle_a: assert property (cs_n [*8] |-> $stable(ptr))
    else $error("pointer moved outside a transfer");
endmodule : srsq_seq_properties

bind srsq_seq srsq_seq_properties u_props (
  .ref_clk   (ref_clk),
  .arst_n    (arst_n),
  .cs_n      (cs_n),
  .sck       (sck),
  .sdo_o     (sdo_o),
  .sdo_oe    (sdo_oe),
  .lock_code (lock_code),
  .wr_valid  (wr_valid),
  .wr_index  (wr_index),
  .wr_ready  (wr_ready),
  .ptr       (ptr)
);

// File: test/srsq_host.sv
// spi host model that frames transfers for the sequencer
`timescale 1ns/1ps
module srsq_host (
  input  wire logic ref_clk,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo_o,
  input  wire logic sdo_oe
);
  logic [31:0] rq [0:7];
  logic        oe_seen;
  int          tail = 0;
  logic        tail_on = 1'b0;

  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
  end

  // ----------------------------------------
  // link timing, sck still between frames
  // ----------------------------------------
  task automatic half;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : half

  // sample just before the next fall, where sdo has long settled
  task automatic bit_io(input logic b, output logic s);
    sck = 1'b0;
    sdi = b;
    half();
    sck = 1'b1;
    half();
    s = sdo_o;
    oe_seen = oe_seen | sdo_oe;
  endtask : bit_io

  task automatic frame(input logic cpol, input logic [7:0] ctrl,
                       input int nw, input int nb, input logic [31:0] wd);
    logic        s;
    logic [31:0] w;
    sck = cpol;
    half();
    cs_n = 1'b0;
    oe_seen = 1'b0;
    half();
    for (int i = 7; i >= 0; i--) bit_io(ctrl[i], s);
    for (int k = 0; k < nw; k++) begin
      w = wd + 32'(k);
      rq[k] = 32'h0;
      for (int i = nb - 1; i >= 0; i--) begin
        bit_io(w[i], s);
        rq[k][i] = s;
      end
    end
    sck = cpol;
    half();
    // optional parked stretch with chip select still low
    tail_on = 1'b1;
    repeat (tail) half();
    tail_on = 1'b0;
    cs_n = 1'b1;
    // released line: never leave the last value standing
    sdi = ~sdi;
    half();
  endtask : frame
endmodule : srsq_host

// File: test/spi_register_access_sequencer_test.sv
// self-checking bench of the serial register access sequencer
`include "srsq_params.svh"
`timescale 1ns/1ps
module spi_register_access_sequencer_test;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cs_n, sck, sdi, sdo_o, sdo_oe;
  logic [1:0]  dev_addr = `SRSQ_DEV_ADDR_RST;
  logic [1:0]  rd_loop = `SRSQ_RD_LOOP_RST;
  logic        wr_loop = `SRSQ_WR_LOOP_RST;
  logic [1:0]  data_width = `SRSQ_WIDTH_24;
  logic [7:0]  lock_code = `SRSQ_LOCK_KEY;
  logic        rdy_n = 1'b1;
  logic        wr_ready = 1'b1;
  logic [31:0] adc_bump = 32'h0;
  logic [4:0]  rd_index, wr_index, ptr;
  logic [31:0] rd_word, wr_data;
  logic        wr_valid, busy;
  logic [36:0] wq [$];
  int          fails = 0;
  int          total_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  // register file stand-in: index-dependent pattern
  assign rd_word = {3'h5, rd_index, 3'h2, rd_index, 8'hC3, rd_index, 3'h6}
                   ^ adc_bump;

  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      wq.push_back({wr_index, wr_data});
    end
  end

  srsq_seq uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .dev_addr(dev_addr), .rd_loop(rd_loop),
    .wr_loop(wr_loop), .data_width(data_width), .lock_code(lock_code),
    .conversion_ready_pulse(rdy_n), .rd_index(rd_index), .rd_word(rd_word),
    .wr_valid(wr_valid), .wr_index(wr_index), .wr_data(wr_data),
    .wr_ready(wr_ready), .busy(busy), .ptr(ptr));

  srsq_host host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .sdi(sdi),
                  .sdo_o(sdo_o), .sdo_oe(sdo_oe));

  // ----------------------------------------
  // helpers and scenarios
  // ----------------------------------------
  function automatic logic [31:0] exp_word(input logic [4:0] i);
    return {8'h00, 3'h2, i, 8'hC3, i, 3'h6};
  endfunction : exp_word

  task automatic check(input string what, input logic [36:0] exp,
                       input logic [36:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results;
    $display("checks %0d failures %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // one pass per loop mode, alternating idle sck level
  task automatic test_read_loops;
    logic [4:0] st [4] = '{5'h0A, 5'h01, 5'h07, 5'h1F};
    logic [4:0] nx [4] = '{5'h0A, 5'h00, 5'h00, 5'h00};
    logic [4:0] pt [4] = '{5'h0A, 5'h01, 5'h01, 5'h01};
    for (int m = 0; m < 4; m++) begin
      rd_loop = 2'(m);
      host.frame(1'(m), {dev_addr, st[m], 1'b1}, 2, 24, 32'h00F0_A55A);
      check("first word", exp_word(st[m]), host.rq[0]);
      check("next word", exp_word(nx[m]), host.rq[1]);
      check("pointer", 37'(pt[m]), 37'(ptr));
    end
    $display("test read_loops done");
  endtask : test_read_loops

  task automatic test_writes;
    logic [36:0] ex [5] = '{{5'h0F, 32'h0012_3456}, {5'h08, 32'h0012_3457},
      {5'h09, 32'h00AB_CDE0}, {5'h09, 32'h00AB_CDE1}, {5'h1F, 32'h0033_3333}};
    wq.delete();
    host.frame(1'b0, {dev_addr, 5'h0F, 1'b0}, 2, 24, 32'h0012_3456);
    check("write oe", 37'h0, 37'(host.oe_seen));
    wr_loop = 1'b0;
    host.frame(1'b1, {dev_addr, 5'h09, 1'b0}, 2, 24, 32'h00AB_CDE0);
    host.frame(1'b0, {dev_addr, 5'h03, 1'b0}, 2, 24, 32'h0011_1111);
    check("stall ptr", 37'h03, 37'(ptr));
    lock_code = 8'h00;
    host.frame(1'b0, {dev_addr, 5'h0A, 1'b0}, 1, 24, 32'h0022_2222);
    host.frame(1'b0, {dev_addr, 5'h1F, 1'b0}, 1, 24, 32'h0033_3333);
    check("write count", 37'd5, 37'(wq.size()));
    foreach (ex[i]) check("write word", ex[i], wq[i]);
    lock_code = `SRSQ_LOCK_KEY;
    $display("test writes done");
  endtask : test_writes

  // far side stalls while six words arrive; only four fit
  task automatic test_fifo;
    wq.delete();
    wr_ready = 1'b0;
    host.frame(1'b1, {dev_addr, 5'h0C, 1'b0}, 6, 24, 32'h0044_4440);
    check("pending busy", 37'h1, 37'(busy));
    wr_ready = 1'b1;
    for (int i = 0; i < 60 && wq.size() < 4; i++) @(posedge ref_clk);
    if (wq.size() < 4) begin
      fails++;
      $display("CHECK FAILED fifo drain expected 4 seen %0d", wq.size());
      results();
    end
    repeat (8) @(posedge ref_clk);
    #1;
    check("drain count", 37'd4, 37'(wq.size()));
    for (int k = 0; k < 4; k++) check("drain word",
      {5'h0C, 32'h0044_4440 + 32'(k)}, wq[k]);
    $display("test fifo done");
  endtask : test_fifo

  task automatic test_abort;
    rd_loop = 2'h0;
    // the data word hides a matching control byte that must be ignored
    host.frame(1'b0, {~dev_addr, 5'h0A, 1'b1}, 1, 24, 32'h0055_5555);
    check("foreign id oe", 37'h0, 37'(host.oe_seen));
    host.frame(1'b1, {dev_addr, 5'h0B, 1'b1}, 1, 5, 32'h0);
    host.frame(1'b0, {dev_addr, 5'h0A, 1'b1}, 1, 24, 32'h0);
    check("after abort", exp_word(5'h0A), host.rq[0]);
    data_width = `SRSQ_WIDTH_32A;
    host.frame(1'b1, {dev_addr, 5'h0A, 1'b1}, 1, 32, 32'h0);
    check("wide word", {8'h05, 5'h0A, 24'(exp_word(5'h0A))},
          host.rq[0]);
    data_width = `SRSQ_WIDTH_24;
    $display("test abort done");
  endtask : test_abort

  // mode 0 parked low: a ready fall puts the fresh msb on the pin
  task automatic test_ready_refresh;
    rd_loop = 2'h0;
    host.tail = 6;
    fork
      host.frame(1'b0, {dev_addr, 5'h02, 1'b1}, 1, 24, 32'h0);
      begin
        for (int i = 0; i < 600 && host.tail_on !== 1'b1; i++)
          @(posedge ref_clk);
        if (host.tail_on !== 1'b1) begin
          fails++;
          $display("CHECK FAILED frame tail expected 1 seen 0");
          results();
        end
        repeat (4) @(posedge ref_clk);
        #1;
        check("parked msb", 37'h0, 37'(sdo_o));
        adc_bump = 32'h0080_0000;
        rdy_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rdy_n = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
        check("ready msb", 37'h1, 37'(sdo_o));
      end
    join
    check("adc word", exp_word(5'h02), host.rq[0]);
    host.tail = 0;
    adc_bump = 32'h0;
    $display("test ready_refresh done");
  endtask : test_ready_refresh

  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    test_read_loops();
    test_writes();
    test_fifo();
    test_abort();
    test_ready_refresh();
    results();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    $display("CHECK FAILED run length expected end seen timeout");
    results();
  end
endmodule : spi_register_access_sequencer_test
